// file: hw/fsr_defs.svh
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// ==========================================================================
// Register map
`define FSR_CSR_OFS 32'h0000_0000
`define FSR_CAUSE_OFS 32'h0000_0004

// ==========================================================================
// Control/status field positions
`define FSR_OVERFLOW_FLAG_BIT 3
`define FSR_UNDERFLOW_FLAG_BIT 4
`define FSR_INEXACT_FLAG_BIT 5
`define FSR_OM_BIT 10
`define FSR_UM_BIT 11
`define FSR_PM_BIT 12
`define FSR_RC_LO 13
`define FSR_RC_HI 14
`define FSR_CSR_WMASK 32'h0000_7c38
`define FSR_CSR_RST 32'h0000_1c00

// ==========================================================================
// Exponent limits, biases and trap scaling
`define FSR_SGL_EMAX 13'sh007f
`define FSR_SGL_EMIN (-13'sh007e)
`define FSR_DBL_EMAX 13'sh03ff
`define FSR_DBL_EMIN (-13'sh03fe)
`define FSR_SGL_BIAS 13'sh007f
`define FSR_DBL_BIAS 13'sh03ff
`define FSR_SGL_SCALE 13'sh00c0
`define FSR_DBL_SCALE 13'sh0600
`define FSR_SGL_EXP_ONES 13'sh00ff
`define FSR_DBL_EXP_ONES 13'sh07ff

`endif

// file: hw/fsr_pkg.sv
package fsr_pkg;

    // ======================================================================
    // Rounding modes in field order.
    typedef enum logic [1:0] {
        FSR_RC_NEAR,
        FSR_RC_DOWN,
        FSR_RC_UP,
        FSR_RC_ZERO
    } fsr_rc_e;

    // ======================================================================
    // One lane as the datapath hands it over: the result rounded with an
    // unbounded exponent, and the same result rounded with a bounded one.
    typedef struct packed {
        logic act;
        logic dbl;
        logic zero;
        logic sign;
        logic signed [12:0] exp;
        logic [51:0] frac;
        logic unb_inexact;
        logic [63:0] bnd;
        logic bnd_inexact;
    } fsr_lane_in_s;

    typedef struct packed {
        logic [63:0] res;
        logic ovf;
        logic unf;
        logic inex;
        logic trap_ovf;
        logic trap_unf;
        logic trap_inex;
    } fsr_lane_out_s;

    typedef struct packed {
        fsr_rc_e rc;
        logic om;
        logic um;
        logic pm;
    } fsr_ctrl_s;

endpackage : fsr_pkg

// file: hw/fsr_lane_resp.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"

module fsr_lane_resp (
    // Lane result and control
    input wire fsr_pkg::fsr_lane_in_s lane,
    input wire fsr_pkg::fsr_ctrl_s ctrl,
    // Response
    output fsr_pkg::fsr_lane_out_s resp
);

    // ======================================================================
    // Encoding
    function automatic logic [63:0] fsr_enc(input logic dbl, input logic s,
                                            input logic [12:0] be, input logic [51:0] f);
        if (dbl) begin
            fsr_enc = {s, be[10:0], f};
        end else begin
            fsr_enc = {32'h0, s, be[7:0], f[51:29]};
        end
    endfunction : fsr_enc

    // ======================================================================
    // Classification
    wire signed [12:0] emax = lane.dbl ? `FSR_DBL_EMAX : `FSR_SGL_EMAX;
    wire signed [12:0] emin = lane.dbl ? `FSR_DBL_EMIN : `FSR_SGL_EMIN;
    wire signed [12:0] bias = lane.dbl ? `FSR_DBL_BIAS : `FSR_SGL_BIAS;
    wire signed [12:0] scale = lane.dbl ? `FSR_DBL_SCALE : `FSR_SGL_SCALE;
    wire signed [12:0] ones = lane.dbl ? `FSR_DBL_EXP_ONES : `FSR_SGL_EXP_ONES;
    wire huge = lane.act && !lane.zero && (lane.exp > emax);
    wire tiny = lane.act && !lane.zero && (lane.exp < emin);
    wire ovf_un = huge && !ctrl.om;
    wire unf_un = tiny && !ctrl.um;

    // ======================================================================
    // Delivered value
    // Under directed rounding the largest finite value is delivered when the
    // rounding moves toward zero for this sign.
    wire use_max = (ctrl.rc == fsr_pkg::FSR_RC_ZERO) ||
                   (ctrl.rc == fsr_pkg::FSR_RC_DOWN && !lane.sign) ||
                   (ctrl.rc == fsr_pkg::FSR_RC_UP && lane.sign);
    wire [63:0] inf_val = fsr_enc(lane.dbl, lane.sign, ones, 52'h0);
    wire [63:0] max_val = fsr_enc(lane.dbl, lane.sign, 13'(ones - 13'sh0001),
                                  {52{1'b1}});
    wire [63:0] ovf_masked = use_max ? max_val : inf_val;
    wire signed [12:0] sc_exp = huge ? 13'(lane.exp - scale + bias)
                                     : 13'(lane.exp + scale + bias);
    wire [63:0] scaled = fsr_enc(lane.dbl, lane.sign, sc_exp, lane.frac);

    // ======================================================================
    // Flags
    wire inex = huge ? (ctrl.om || lane.unb_inexact)
              : unf_un ? lane.unb_inexact
              : lane.bnd_inexact;

    assign resp.res = (ovf_un || unf_un) ? scaled : huge ? ovf_masked : lane.bnd;
    assign resp.ovf = huge;
    assign resp.unf = tiny && (unf_un || lane.bnd_inexact);
    assign resp.inex = lane.act && inex;
    assign resp.trap_ovf = ovf_un;
    assign resp.trap_unf = unf_un;
    assign resp.trap_inex = lane.act && inex && !ctrl.pm;

endmodule : fsr_lane_resp

// file: hw/fsr_exc_unit.sv
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fsr_defs.svh"

module fsr_exc_unit #(
    parameter int LANES = 4
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Operation results from the datapath
    input wire logic op_valid,
    input wire fsr_pkg::fsr_lane_in_s [LANES-1:0] op_lanes,
    // Delivered results and exception
    output logic res_valid,
    output logic [LANES-1:0][63:0] res_data,
    output logic fp_exc
);

    // ======================================================================
    // Bus address phase
    // Only whole-word singles are used, so hsize is accepted as given.
    wire addr_take = hsel && htrans[1] && hready;
    wire is_csr = (haddr[31:2] == 30'(`FSR_CSR_OFS >> 2));
    wire is_cause = (haddr[31:2] == 30'(`FSR_CAUSE_OFS >> 2));

    logic wr_csr_reg;
    logic wr_csr_next;
    logic ready_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    assign wr_csr_next = addr_take && hwrite && is_csr;

    // ======================================================================
    // Control/status register
    logic [31:0] csr_reg;
    logic [31:0] csr_next;
    logic [2:0] cause_reg;
    logic [2:0] cause_next;
    fsr_pkg::fsr_ctrl_s ctrl;

    assign ctrl.rc = fsr_pkg::fsr_rc_e'(csr_reg[`FSR_RC_HI:`FSR_RC_LO]);
    assign ctrl.om = csr_reg[`FSR_OM_BIT];
    assign ctrl.um = csr_reg[`FSR_UM_BIT];
    assign ctrl.pm = csr_reg[`FSR_PM_BIT];

    // ======================================================================
    // Lanes
    fsr_pkg::fsr_lane_out_s [LANES-1:0] lane_out;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        fsr_lane_resp u_lane (
            .lane(op_lanes[i]),
            .ctrl(ctrl),
            .resp(lane_out[i])
        );
    end

    function automatic logic [5:0] fsr_or_lanes(
        input fsr_pkg::fsr_lane_out_s [LANES-1:0] lo);
        logic [5:0] acc;
        acc = 6'h00;
        for (int k = 0; k < LANES; k++) begin
            acc = acc | {lo[k].ovf, lo[k].unf, lo[k].inex,
                         lo[k].trap_ovf, lo[k].trap_unf, lo[k].trap_inex};
        end
        fsr_or_lanes = acc;
    endfunction : fsr_or_lanes

    wire [5:0] any = op_valid ? fsr_or_lanes(lane_out) : 6'h00;
    wire any_trap = |any[2:0];

    // A write and a flag event in one cycle: the event wins, so no
    // exception is lost to a clearing write.
    wire [31:0] csr_base = wr_csr_reg ? (hwdata & `FSR_CSR_WMASK) : csr_reg;
    wire [31:0] evt_bits = (32'(any[5]) << `FSR_OVERFLOW_FLAG_BIT) |
                           (32'(any[4]) << `FSR_UNDERFLOW_FLAG_BIT) |
                           (32'(any[3]) << `FSR_INEXACT_FLAG_BIT);
    assign csr_next = csr_base | evt_bits;
    assign cause_next = any_trap ? any[2:0] : cause_reg;

    // Read data is sampled in the address phase from the next-state value,
    // so a read right after a write sees the written value.
    assign rdata_next = (addr_take && !hwrite && is_csr) ? csr_next
                      : (addr_take && !hwrite && is_cause) ? {29'h0, cause_next}
                      : 32'h0;

    // ======================================================================
    // Registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_csr_reg <= 1'b0;
            ready_reg <= 1'b0;
            rdata_reg <= 32'h0;
            csr_reg <= `FSR_CSR_RST;
            cause_reg <= 3'h0;
        end else if (ce) begin
            wr_csr_reg <= wr_csr_next;
            ready_reg <= 1'b1;
            rdata_reg <= rdata_next;
            csr_reg <= csr_next;
            cause_reg <= cause_next;
        end
    end

    logic res_valid_reg;
    logic fp_exc_reg;
    logic [LANES-1:0][63:0] res_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            res_valid_reg <= 1'b0;
            fp_exc_reg <= 1'b0;
            res_reg <= '0;
        end else if (ce) begin
            res_valid_reg <= op_valid;
            fp_exc_reg <= any_trap;
            for (int k = 0; k < LANES; k++) begin
                if (op_valid) begin
                    res_reg[k] <= lane_out[k].res;
                end
            end
        end
    end

    assign hreadyout = ready_reg;
    assign hrdata = rdata_reg;
    assign hresp = 1'b0;
    assign res_valid = res_valid_reg;
    assign res_data = res_reg;
    assign fp_exc = fp_exc_reg;

    // ======================================================================
    // Checks on lane 0 and on the control/status register
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire fsr_pkg::fsr_lane_in_s l0 = op_lanes[0];
    wire l0_go = ce && op_valid && l0.act && !l0.zero;
    wire l0_sgl_huge = l0_go && !l0.dbl && (l0.exp > `FSR_SGL_EMAX);
    wire l0_dbl_huge = l0_go && l0.dbl && (l0.exp > `FSR_DBL_EMAX);
    wire l0_sgl_tiny = l0_go && !l0.dbl && (l0.exp < `FSR_SGL_EMIN);
    wire l0_dbl_tiny = l0_go && l0.dbl && (l0.exp < `FSR_DBL_EMIN);
    wire l0_plain = l0_go && !l0_sgl_huge && !l0_dbl_huge && !l0_sgl_tiny && !l0_dbl_tiny;
    wire [7:0] l0_sgl_ovf_exp = 8'(l0.exp - `FSR_SGL_SCALE + `FSR_SGL_BIAS);
    wire [7:0] l0_sgl_unf_exp = 8'(l0.exp + `FSR_SGL_SCALE + `FSR_SGL_BIAS);

    property p_sgl_ovf_near;
        l0_sgl_huge && ctrl.om && ctrl.rc == fsr_pkg::FSR_RC_NEAR
        |=> res_data[0] == {32'h0, $past(l0.sign), 31'h7f80_0000}
            && csr_reg[`FSR_OVERFLOW_FLAG_BIT] && csr_reg[`FSR_INEXACT_FLAG_BIT];
    endproperty
    a_sgl_ovf_near: assert property (p_sgl_ovf_near) else $error("masked overflow not inf");

    property p_sgl_ovf_zero;
        l0_sgl_huge && ctrl.om && ctrl.rc == fsr_pkg::FSR_RC_ZERO && !l0.sign
        |=> res_data[0] == 64'h0000_0000_7f7f_ffff;
    endproperty
    a_sgl_ovf_zero: assert property (p_sgl_ovf_zero) else $error("toward zero not max");

    property p_dbl_ovf_up;
        l0_dbl_huge && ctrl.om && ctrl.rc == fsr_pkg::FSR_RC_UP && l0.sign
        |=> res_data[0] == 64'hffef_ffff_ffff_ffff && csr_reg[`FSR_OVERFLOW_FLAG_BIT];
    endproperty
    a_dbl_ovf_up: assert property (p_dbl_ovf_up) else $error("double max not delivered");

    property p_sgl_ovf_trap;
        l0_sgl_huge && !ctrl.om
        |=> fp_exc && res_data[0][30:23] == $past(l0_sgl_ovf_exp) && cause_reg[2]
            && csr_reg[`FSR_OVERFLOW_FLAG_BIT];
    endproperty
    a_sgl_ovf_trap: assert property (p_sgl_ovf_trap) else $error("overflow trap wrong");

    property p_sgl_unf_trap;
        l0_sgl_tiny && !ctrl.um
        |=> fp_exc && res_data[0][30:23] == $past(l0_sgl_unf_exp)
            && csr_reg[`FSR_UNDERFLOW_FLAG_BIT];
    endproperty
    a_sgl_unf_trap: assert property (p_sgl_unf_trap) else $error("underflow trap wrong");

    property p_unf_masked;
        (l0_sgl_tiny || l0_dbl_tiny) && ctrl.um
        |=> res_data[0] == $past(l0.bnd);
    endproperty
    a_unf_masked: assert property (p_unf_masked) else $error("masked underflow value");

    property p_inex_masked;
        l0_plain && l0.bnd_inexact && ctrl.pm
        |=> res_data[0] == $past(l0.bnd) && csr_reg[`FSR_INEXACT_FLAG_BIT];
    endproperty
    a_inex_masked: assert property (p_inex_masked) else $error("inexact masked wrong");

    property p_inex_unmasked;
        l0_plain && l0.bnd_inexact && !ctrl.pm
        |=> fp_exc && cause_reg[0] && csr_reg[`FSR_INEXACT_FLAG_BIT];
    endproperty
    a_inex_unmasked: assert property (p_inex_unmasked) else $error("inexact trap missing");

    property p_sticky;
        csr_reg[`FSR_OVERFLOW_FLAG_BIT] && !wr_csr_reg |=> csr_reg[`FSR_OVERFLOW_FLAG_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("overflow flag dropped");

    property p_rc_write;
        ce && wr_csr_reg
        |=> csr_reg[`FSR_RC_HI:`FSR_RC_LO] == $past(hwdata[`FSR_RC_HI:`FSR_RC_LO]);
    endproperty
    a_rc_write: assert property (p_rc_write) else $error("rounding field not written");

    c_ovf_masked: cover property (l0_sgl_huge && ctrl.om);
    c_unf_trap: cover property (l0_dbl_tiny && !ctrl.um);
    c_csr_write: cover property (ce && wr_csr_reg ##1 res_valid);

endmodule : fsr_exc_unit

// file: test/tb_fsr_exc_unit.sv
`timescale 1ns/1ps

module tb_fsr_exc_unit;
    // ======================================================================
    // Signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic op_valid = 1'b0;
    fsr_pkg::fsr_lane_in_s [3:0] op_lanes = '0;
    logic res_valid;
    logic [3:0][63:0] res_data;
    logic fp_exc;
    int err_total = 0;
    int num_checks = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    // The one slave's ready is the bus ready.
    fsr_exc_unit fsr_exc_unit_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .op_valid(op_valid), .op_lanes(op_lanes), .res_valid(res_valid),
        .res_data(res_data), .fp_exc(fp_exc));

    // ======================================================================
    // Checking and bus tasks
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Ready and read data come from flops, so the values seen at a rising edge
    // are the ones that stood through the cycle which that edge ends.
    task automatic wait_rdy(output logic [31:0] d);
        for (int n = 0; n < 50; n++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) begin
                d = hrdata;
                return;
            end
        end
        err_total++;
        tally_and_finish();
    endtask : wait_rdy

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic [31:0] dummy;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy(dummy);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask : ahb

    task automatic op(input fsr_pkg::fsr_lane_in_s [3:0] ln);
        op_lanes <= ln;
        op_valid <= 1'b1;
        @(posedge clock);
        op_valid <= 1'b0;
        // Results stand through the next cycle and are looked at as it ends.
        @(posedge clock);
    endtask : op

    // ======================================================================
    // Reference model of one lane: {ovf, unf, inex, result}
    function automatic logic [66:0] model(input fsr_pkg::fsr_lane_in_s l,
                                          input logic [1:0] rc, input logic om,
                                          input logic um);
        int emax, emin, bias, sc, be;
        logic big, tiny, mx;
        logic [63:0] r;
        emax = l.dbl ? 1023 : 127;
        emin = l.dbl ? -1022 : -126;
        bias = l.dbl ? 1023 : 127;
        sc = l.dbl ? 1536 : 192;
        big = !l.zero && (l.exp > emax);
        tiny = !l.zero && (l.exp < emin);
        mx = (rc == 2'h3) || (rc == 2'h1 && !l.sign) || (rc == 2'h2 && l.sign);
        if (!l.act) return {3'h0, l.bnd};
        if (big && om) begin
            r = l.dbl ? {l.sign, mx ? 11'h7fe : 11'h7ff, mx ? {52{1'b1}} : 52'h0}
                      : {32'h0, l.sign, mx ? 8'hfe : 8'hff, mx ? 23'h7fffff : 23'h0};
            return {3'h5, r};
        end
        if (big || (tiny && !um)) begin
            be = big ? int'(l.exp) - sc + bias : int'(l.exp) + sc + bias;
            r = l.dbl ? {l.sign, be[10:0], l.frac} : {32'h0, l.sign, be[7:0], l.frac[51:29]};
            return {big, !big, l.unb_inexact, r};
        end
        if (tiny) return {1'b0, l.bnd_inexact, l.bnd_inexact, l.bnd};
        return {2'h0, l.bnd_inexact, l.bnd};
    endfunction : model

    // Kinds: 0 overflow, 1 underflow, 2 normal, 3 unused lane, 4 tiny zero,
    // 5 exponent exactly at a limit.
    task automatic gen(input int k, output fsr_pkg::fsr_lane_in_s l);
        logic [63:0] rv;
        int e;
        int emax;
        int emin;
        rv = {$urandom, $urandom};
        l.frac = rv[51:0];
        l.bnd = {$urandom, $urandom};
        l.act = (k != 3);
        l.dbl = $urandom % 2;
        l.sign = $urandom % 2;
        l.zero = (k == 4);
        l.unb_inexact = $urandom % 2;
        l.bnd_inexact = $urandom % 2;
        if (!l.dbl) l.bnd[63:32] = 32'h0;
        emax = l.dbl ? 1023 : 127;
        emin = l.dbl ? -1022 : -126;
        case (k)
            0: e = emax + 1 + int'($urandom % 200);
            1, 4: e = emin - 1 - int'($urandom % 60);
            5: e = ($urandom % 2) ? emax : emin;
            default: e = int'($urandom % 200) - 100;
        endcase
        l.exp = e[12:0];
    endtask : gen

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [31:0] wv;
        logic [31:0] flags;
        logic [31:0] cause;
        logic [66:0] m;
        logic [2:0] tr;
        logic [2:0] mk;
        logic [1:0] rc;
        logic [63:0] held;
        logic [66:0] exp_q[$];
        fsr_pkg::fsr_lane_in_s [3:0] ln;
        void'($urandom(96));
        repeat (12) @(posedge clock);
        chk("hreadyout in reset", 64'h0, {63'h0, hreadyout});
        chk("res_valid in reset", 64'h0, {63'h0, res_valid});
        chk("res_data in reset", 64'h0, res_data[0]);
        chk("fp_exc in reset", 64'h0, {63'h0, fp_exc});
        rst_n <= 1'b1;
        @(posedge clock);
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk("csr reset", 64'h1c00, {32'h0, rd});
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk("cause reset", 64'h0, {32'h0, rd});
        ahb(1'b1, 32'h4, 32'hffffffff, rd);
        ahb(1'b1, 32'h40, 32'hffffffff, rd);
        ahb(1'b0, 32'h40, 32'h0, rd);
        chk("unmapped", 64'h0, {32'h0, rd});
        ahb(1'b0, 32'h4, 32'h0, rd);
        chk("cause read only", 64'h0, {32'h0, rd});
        chk("hresp", 64'h0, {63'h0, hresp});
        chk("hreadyout", 64'h1, {63'h0, hreadyout});
        flags = 32'h0;
        cause = 32'h0;
        for (int i = 0; i < 64; i++) begin
            rc = i[1:0];
            mk = i[4:2];
            // Odd passes clear the flags, even ones keep them to show stickiness.
            wv = {17'h0, rc, mk, 10'h0} | (i[0] ? 32'h0 : flags);
            ahb(1'b1, 32'h0, wv, rd);
            flags = wv & 32'h38;
            tr = 3'h0;
            for (int j = 0; j < 4; j++) begin
                gen(int'($urandom % 6), ln[j]);
                exp_q.push_back(model(ln[j], rc, mk[0], mk[1]));
            end
            op(ln);
            chk("res_valid", 64'h1, {63'h0, res_valid});
            for (int j = 0; j < 4; j++) begin
                m = exp_q.pop_front();
                chk("res_data", m[63:0], res_data[j]);
                flags |= {26'h0, m[64], m[65], m[66], 3'h0};
                tr |= {m[66] & !mk[0], m[65] & !mk[1], m[64] & !mk[2]};
            end
            chk("fp_exc", {63'h0, |tr}, {63'h0, fp_exc});
            if (|tr) cause = {29'h0, tr};
            ahb(1'b0, 32'h0, 32'h0, rd);
            chk("csr flags", {32'h0, (wv & 32'h7c00) | flags}, {32'h0, rd});
            ahb(1'b0, 32'h4, 32'h0, rd);
            chk("cause", {32'h0, cause}, {32'h0, rd});
        end
        // With the enable low an unmasked overflow must leave every flop alone.
        ahb(1'b1, 32'h0, 32'h0, rd);
        held = res_data[0];
        for (int j = 0; j < 4; j++) begin
            gen(0, ln[j]);
        end
        ce <= 1'b0;
        op(ln);
        chk("frozen res_valid", 64'h0, {63'h0, res_valid});
        chk("frozen res_data", held, res_data[0]);
        chk("frozen fp_exc", 64'h0, {63'h0, fp_exc});
        ce <= 1'b1;
        ahb(1'b0, 32'h0, 32'h0, rd);
        chk("frozen csr", 64'h0, {32'h0, rd});
        tally_and_finish();
    end
endmodule : tb_fsr_exc_unit
